/* verilog/nibble_device.sv */
// Nibble end: per-lane input/output delay taps, datapath resets, idle pad levels,
// tristate selection and calibration-enable gating; pads and chain ports on the user side.
// Assumes the fabric end drives the interface synchronously to REF_CLK.
`timescale 1ns/1ps
// Operation
// [R1] Nibble reset clears all paths and delays
// [R2] Nibble reset forces pads and tristate idle
// [R3] Select zero steers controls to input delay
// [R4] Select one steers controls to output delay
// [R5] Rx enable allows alignment and delay calibration
// [R6] Tx enable allows only delay calibration
// [R7] Enable plus global enable gives tracking
// [R8] Fabric drops both enables before delay change
// [R9] Register-port updates keep both enables high; step and load writes here drop both on their lanes
// [R10] Rx lane reset clears receive, keeps delay
// [R11] Tx lane reset clears transmit, keeps delay
// [R12] Tx lane reset forces pad and tristate idle
// [R13] Direct tristate input is purely combinational
// [R14] Start output goes to previous nibble
// [R15] Stop output to next, else own start
// [R16] Cross-byte clocks only to other nibbles
// [R17] Nibble six to eight uses downward clock
// [R18] Readback carries nine bits per lane
// [R19] Fabric synchronises resets and calibration enables
module nibble_device (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  nibble_if.device         ctl,
  // Lane data and idle levels
  input  wire logic [5:0]  TX_DATA,
  input  wire logic [5:0]  TX_IDLE,
  input  wire logic        TRI_IDLE,
  input  wire logic [5:0]  RX_PAD,
  output      logic [5:0]  TX_PAD,
  output      logic [5:0]  TRI_CTL,
  output      logic [5:0]  RX_DATA,
  // Calibration status per lane
  output      logic [5:0]  RX_ALIGN_CAL,
  output      logic [5:0]  RX_DELAY_CAL,
  output      logic [5:0]  TX_DELAY_CAL,
  output      logic [5:0]  RX_TRACK,
  output      logic [5:0]  TX_TRACK,
  // Calibration chain and cross-byte clocks
  input  wire logic        CALIB_START_IN,
  input  wire logic        CALIB_STOP_IN,
  input  wire logic        CROSS_BYTE_CLK_IN,
  output      logic        CALIB_START_OUT,
  output      logic        CALIB_STOP_OUT,
  output      logic        CROSS_BYTE_CLK_DOWN,
  output      logic        CROSS_BYTE_CLK_UP
);
  // Tap storage and registered pad-side state
  logic [8:0]  in_tap_r   [6];
  logic [8:0]  out_tap_r  [6];
  logic [5:0]  tx_pad_r;
  logic [5:0]  tri_reg_r;
  logic [5:0]  rx_data_r;
  logic [53:0] readback_r;
  // Calibration status mirrors
  logic [5:0]  rx_align_r;
  logic [5:0]  rx_delay_r;
  logic [5:0]  tx_delay_r;
  logic [5:0]  rx_track_r;
  logic [5:0]  tx_track_r;
  // Chain relay state
  logic        start_r;
  logic        stop_r;
  logic        xclk_r;
  // Shared decode
  wire  [5:0]  tri_mux;
  wire         nib_clear;
  wire  [5:0]  rx_track_nxt;
  wire  [5:0]  tx_track_nxt;
  wire         stop_nxt;

  assign nib_clear = SRST | ctl.nib_rst;

  genvar k;
  generate
    for (k = 0; k < nibble_pkg::LANES; k++) begin : g_lane
      // Path steering and per-lane holds
      wire       act_in;
      wire       act_out;
      wire [8:0] ld_val;
      wire       in_load;
      wire       in_step;
      wire       out_load;
      wire       out_step;
      wire [8:0] in_nxt;
      wire [8:0] out_nxt;
      wire [8:0] sel_tap;
      wire       tx_hold;
      wire       rx_hold;
      wire       tri_pick;

      assign act_in   = ~ctl.delay_path_select[k]; // R3
      assign act_out  = ctl.delay_path_select[k];  // R4
      assign ld_val   = ctl.delay_load_value[9*k +: 9];
      assign in_load  = act_in & ctl.delay_load[k];
      assign in_step  = act_in & ctl.dly_step[k];
      assign out_load = act_out & ctl.delay_load[k];
      assign out_step = act_out & ctl.dly_step[k];
      assign in_nxt   = ctl.dly_inc[k] ? in_tap_r[k] + 9'h001 : in_tap_r[k] - 9'h001;
      assign out_nxt  = ctl.dly_inc[k] ? out_tap_r[k] + 9'h001 : out_tap_r[k] - 9'h001;
      assign sel_tap  = act_out ? out_tap_r[k] : in_tap_r[k];
      assign tx_hold  = nib_clear | ctl.tx_rst[k];
      assign rx_hold  = nib_clear | ctl.rx_rst[k];
      assign tri_pick = ctl.tristate_source_select[k] ? ctl.tri_direct[k] : tri_reg_r[k];

      // Lane resets leave the taps alone so a datapath flush never costs calibration
      always_ff @(posedge REF_CLK) begin
        if (nib_clear) begin
          in_tap_r[k] <= nibble_pkg::TAP_RST; // R1
        end else if (in_load) begin
          in_tap_r[k] <= ld_val; // R3
        end else if (in_step) begin
          in_tap_r[k] <= in_nxt; // R3
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (nib_clear) begin
          out_tap_r[k] <= nibble_pkg::TAP_RST; // R1
        end else if (out_load) begin
          out_tap_r[k] <= ld_val; // R4
        end else if (out_step) begin
          out_tap_r[k] <= out_nxt; // R4
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (tx_hold) begin
          tx_pad_r[k] <= TX_IDLE[k]; // R2 R11 R12
        end else begin
          tx_pad_r[k] <= TX_DATA[k];
        end
      end

      // Registered tristate travels with transmit data and drives once out of reset
      always_ff @(posedge REF_CLK) begin
        if (tx_hold) begin
          tri_reg_r[k] <= TRI_IDLE; // R2 R12
        end else begin
          tri_reg_r[k] <= 1'b0;
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (rx_hold) begin
          rx_data_r[k] <= 1'b0; // R1 R10
        end else begin
          rx_data_r[k] <= RX_PAD[k];
        end
      end

      // Direct route bypasses every flop; the idle level still wins during reset
      assign tri_mux[k] = tx_hold ? TRI_IDLE : tri_pick; // R13

      always_ff @(posedge REF_CLK) begin
        readback_r[9*k +: 9] <= sel_tap; // R18
      end
    end
  endgenerate

  // Status trails the enables by one cycle so that every status output leaves a flop
  assign rx_track_nxt = ctl.rx_calib_enable & {6{ctl.global_tracking_enable}}; // R7
  assign tx_track_nxt = ctl.tx_calib_enable & {6{ctl.global_tracking_enable}}; // R7

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rx_align_r <= nibble_pkg::LANE_RST;
      rx_delay_r <= nibble_pkg::LANE_RST;
      tx_delay_r <= nibble_pkg::LANE_RST;
      rx_track_r <= nibble_pkg::LANE_RST;
      tx_track_r <= nibble_pkg::LANE_RST;
    end else begin
      rx_align_r <= ctl.rx_calib_enable; // R5
      rx_delay_r <= ctl.rx_calib_enable; // R5
      tx_delay_r <= ctl.tx_calib_enable; // R6
      rx_track_r <= rx_track_nxt;        // R7
      tx_track_r <= tx_track_nxt;        // R7
    end
  end

  // Chain ports pass tokens one cycle late; wiring of neighbours is left to the board
  assign stop_nxt = CALIB_START_IN | CALIB_STOP_IN;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      start_r <= 1'b0;
    end else begin
      start_r <= CALIB_STOP_IN; // R14 R15
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      stop_r <= 1'b0;
    end else begin
      stop_r <= stop_nxt; // R15
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      xclk_r <= 1'b0;
    end else begin
      xclk_r <= CROSS_BYTE_CLK_IN; // R16 R17
    end
  end

  assign ctl.delay_readback  = readback_r;
  assign TX_PAD              = tx_pad_r;
  assign TRI_CTL             = tri_mux;
  assign RX_DATA             = rx_data_r;
  assign RX_ALIGN_CAL        = rx_align_r;
  assign RX_DELAY_CAL        = rx_delay_r;
  assign TX_DELAY_CAL        = tx_delay_r;
  assign RX_TRACK            = rx_track_r;
  assign TX_TRACK            = tx_track_r;
  assign CALIB_START_OUT     = start_r;
  assign CALIB_STOP_OUT      = stop_r;
  assign CROSS_BYTE_CLK_DOWN = xclk_r;
  assign CROSS_BYTE_CLK_UP   = xclk_r;
endmodule

/* include/nibble_pkg.sv */
// Shared constants for the nibble reset, delay-select and calibration-enable control.
// Assumes one control clock and a synchronous active-high reset on both ends.
package nibble_pkg;
  localparam int LANES      = 6;
  localparam int TAP_W      = 9;
  localparam int READBACK_W = LANES * TAP_W;
  localparam logic [8:0] TAP_RST = 9'h000;
  localparam logic [5:0] LANE_RST = 6'h00;
  // Software register indices of the fabric-side controller
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SELECT  = 4'h1;
  localparam logic [3:0] REG_RXCAL   = 4'h2;
  localparam logic [3:0] REG_TXCAL   = 4'h3;
  localparam logic [3:0] REG_RXRST   = 4'h4;
  localparam logic [3:0] REG_TXRST   = 4'h5;
  localparam logic [3:0] REG_TRISRC  = 4'h6;
  localparam logic [3:0] REG_TRIDIR  = 4'h7;
  localparam logic [3:0] REG_STEP    = 4'h8;
  localparam logic [3:0] REG_LOADVAL = 4'h9;
  localparam logic [3:0] REG_RBLANE  = 4'hA;
  localparam logic [3:0] REG_RBVAL   = 4'hB;
  localparam logic [3:0] REG_CHAIN   = 4'hC;
  // Control register field positions
  localparam int CTRL_RST_BIT   = 0;
  localparam int CTRL_TRACK_BIT = 1;
  // Step register field positions
  localparam int STEP_INC_BIT  = 8;
  localparam int STEP_LOAD_BIT = 9;
  // Cycles the fabric waits after dropping calibration enables before stepping
  localparam int CAL_SETTLE_CYC = 2;
endpackage

/* include/nibble_if.sv */
// Interface joining the nibble control logic and the fabric control logic.
// Assumes both ends run on the same control clock.
`timescale 1ns/1ps
interface nibble_if;
  logic        nib_rst;
  logic [5:0]  delay_path_select;
  logic [5:0]  dly_step;
  logic [5:0]  dly_inc;
  logic [5:0]  delay_load;
  logic [53:0] delay_load_value;
  logic [53:0] delay_readback;
  logic [5:0]  rx_calib_enable;
  logic [5:0]  tx_calib_enable;
  logic        global_tracking_enable;
  logic [5:0]  rx_rst;
  logic [5:0]  tx_rst;
  logic [5:0]  tristate_source_select;
  logic [5:0]  tri_direct;
  modport device (
    input  nib_rst, delay_path_select, dly_step, dly_inc, delay_load, delay_load_value,
    input  rx_calib_enable, tx_calib_enable, global_tracking_enable,
    input  rx_rst, tx_rst, tristate_source_select, tri_direct,
    output delay_readback
  );
  modport fabric (
    output nib_rst, delay_path_select, dly_step, dly_inc, delay_load, delay_load_value,
    output rx_calib_enable, tx_calib_enable, global_tracking_enable,
    output rx_rst, tx_rst, tristate_source_select, tri_direct,
    input  delay_readback
  );
endinterface

/* verilog/nibble_fabric.sv */
// Fabric end: software registers driving the nibble controls over the interface.
// Assumes a simple strobe port master on REF_CLK; asynchronous requests synchronised here.
`timescale 1ns/1ps
module nibble_fabric (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        SRST,
  nibble_if.fabric         ctl,
  // Software port
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output      logic [15:0] RDATA,
  // Asynchronous reset request from elsewhere
  input  wire logic        ASYNC_RST_REQ
);
  logic [15:0] ctrl_r, sel_r, rxcal_r, txcal_r, rxrst_r, txrst_r, trisrc_r, tridir_r;
  logic [15:0] loadval_r, rblane_r, rdata_r;
  logic [5:0]  step_r, inc_r, load_r, hold_r;
  logic [2:0]  arst_sync_r;
  logic        arst_r;
  logic [1:0]  settle_r;
  wire  step_wr = WR && (ADDR == nibble_pkg::REG_STEP);
  wire  busy    = settle_r != 2'h0;
  wire [5:0] lanes = WDATA[5:0];
  wire [53:0] ldv = {6{loadval_r[8:0]}};
  wire [8:0]  rb_sel = ctl.delay_readback[9*rblane_r[2:0] +: 9];
  wire [15:0] rd_mux =
    (ADDR == nibble_pkg::REG_CTRL)    ? ctrl_r    :
    (ADDR == nibble_pkg::REG_SELECT)  ? sel_r     :
    (ADDR == nibble_pkg::REG_RXCAL)   ? rxcal_r   :
    (ADDR == nibble_pkg::REG_TXCAL)   ? txcal_r   :
    (ADDR == nibble_pkg::REG_RXRST)   ? rxrst_r   :
    (ADDR == nibble_pkg::REG_TXRST)   ? txrst_r   :
    (ADDR == nibble_pkg::REG_TRISRC)  ? trisrc_r  :
    (ADDR == nibble_pkg::REG_TRIDIR)  ? tridir_r  :
    (ADDR == nibble_pkg::REG_LOADVAL) ? loadval_r :
    (ADDR == nibble_pkg::REG_RBLANE)  ? rblane_r  :
    (ADDR == nibble_pkg::REG_RBVAL)   ? {7'h00, rb_sel} :
    (ADDR == nibble_pkg::REG_CHAIN)   ? {15'h0000, busy} : 16'h0000;

  function automatic logic [15:0] wr6(input logic [15:0] cur, input logic [3:0] a);
    wr6 = (WR && ADDR == a) ? {10'h000, WDATA[5:0]} : cur;
  endfunction

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ctrl_r <= 16'h0000; sel_r <= 16'h0000; rxcal_r <= 16'h0000; txcal_r <= 16'h0000;
      rxrst_r <= 16'h0000; txrst_r <= 16'h0000; trisrc_r <= 16'h0000; tridir_r <= 16'h0000;
      loadval_r <= 16'h0000; rblane_r <= 16'h0000; rdata_r <= 16'h0000;
    end else begin
      ctrl_r    <= (WR && ADDR == nibble_pkg::REG_CTRL) ? {14'h0000, WDATA[1:0]} : ctrl_r;
      sel_r     <= wr6(sel_r, nibble_pkg::REG_SELECT);
      rxcal_r   <= wr6(rxcal_r, nibble_pkg::REG_RXCAL);
      txcal_r   <= wr6(txcal_r, nibble_pkg::REG_TXCAL);
      rxrst_r   <= wr6(rxrst_r, nibble_pkg::REG_RXRST);
      txrst_r   <= wr6(txrst_r, nibble_pkg::REG_TXRST);
      trisrc_r  <= wr6(trisrc_r, nibble_pkg::REG_TRISRC);
      tridir_r  <= wr6(tridir_r, nibble_pkg::REG_TRIDIR);
      loadval_r <= (WR && ADDR == nibble_pkg::REG_LOADVAL) ? {7'h00, WDATA[8:0]} : loadval_r;
      rblane_r  <= (WR && ADDR == nibble_pkg::REG_RBLANE) ? {13'h0000, WDATA[2:0]} : rblane_r;
      rdata_r   <= RD ? rd_mux : 16'h0000;
    end
  end

  // Step request: drop calibration enables, wait, then pulse one step or load
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      step_r <= 6'h00; inc_r <= 6'h00; load_r <= 6'h00; hold_r <= 6'h00; settle_r <= 2'h0;
    end else if (step_wr && !busy) begin
      hold_r   <= lanes;
      inc_r    <= WDATA[nibble_pkg::STEP_INC_BIT] ? lanes : 6'h00;
      step_r   <= 6'h00;
      settle_r <= 2'(nibble_pkg::CAL_SETTLE_CYC);
      load_r   <= WDATA[nibble_pkg::STEP_LOAD_BIT] ? 6'h3F : 6'h00;
    end else if (settle_r == 2'h1) begin
      step_r   <= (load_r != 6'h00) ? 6'h00 : hold_r;
      load_r   <= load_r & hold_r;
      settle_r <= 2'h0;
    end else if (busy) begin
      settle_r <= settle_r - 2'h1;
    end else begin
      step_r <= 6'h00; load_r <= 6'h00; hold_r <= 6'h00;
    end
  end

  // Three-stage capture; a change counts once the last two stages agree
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      arst_sync_r <= 3'h0;
      arst_r      <= 1'b0;
    end else begin
      arst_sync_r <= {arst_sync_r[1:0], ASYNC_RST_REQ};
      if (arst_sync_r[2] == arst_sync_r[1])
        arst_r <= arst_sync_r[2]; // R19
    end
  end

  wire pulse = (step_r != 6'h00) || (load_r != 6'h00 && !busy);
  assign ctl.nib_rst = ctrl_r[nibble_pkg::CTRL_RST_BIT] | arst_r;
  assign ctl.global_tracking_enable = ctrl_r[nibble_pkg::CTRL_TRACK_BIT];
  assign ctl.delay_path_select = sel_r[5:0];
  assign ctl.rx_calib_enable = rxcal_r[5:0] & ~hold_r; // R8
  assign ctl.tx_calib_enable = txcal_r[5:0] & ~hold_r; // R8 R9
  assign ctl.rx_rst = rxrst_r[5:0];
  assign ctl.tx_rst = txrst_r[5:0];
  assign ctl.tristate_source_select = trisrc_r[5:0];
  assign ctl.tri_direct = tridir_r[5:0];
  assign ctl.dly_step = pulse ? step_r : 6'h00;
  assign ctl.dly_inc = inc_r;
  assign ctl.delay_load = (pulse && !busy) ? load_r : 6'h00;
  assign ctl.delay_load_value = ldv;
  assign RDATA = rdata_r;
endmodule

/* testbench/nibble_chk_sva.sv */
// Checker on the control interface between the fabric end and the nibble end.
// Assumes one clock, synchronous active-high reset, readback registered once.
`timescale 1ns/1ps
module nibble_chk (
  // Clock and reset
  input logic        REF_CLK,
  input logic        SRST,
  // Interface signals
  input logic        nib_rst,
  input logic [5:0]  delay_path_select,
  input logic [5:0]  dly_step,
  input logic [5:0]  dly_inc,
  input logic [5:0]  delay_load,
  input logic [53:0] delay_load_value,
  input logic [53:0] delay_readback,
  input logic [5:0]  rx_calib_enable,
  input logic [5:0]  tx_calib_enable,
  input logic [5:0]  rx_rst,
  input logic [5:0]  tx_rst
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  wire       quiet = (dly_step == 6'h00) && (delay_load == 6'h00) && !nib_rst;
  wire [5:0] act   = dly_step | delay_load;
  wire [5:0] cal   = rx_calib_enable | tx_calib_enable;
  wire       lrst  = |(rx_rst | tx_rst);
  rst_clears_a: assert property (nib_rst [*2] |=> delay_readback == 54'h0)
    else $error("readback not cleared by nibble reset");
  step_quiet_a: assert property (|act |-> (act & cal) == 6'h00)
    else $error("delay changed with calibration enabled");
  settle_a: assert property (|act |-> (($past(cal) | $past(cal, 2)) & act) == 6'h00)
    else $error("calibration enables not settled before change");
  pulse_single_a: assert property (|act |=> act == 6'h00)
    else $error("delay control longer than one cycle");
  hold_still_a: assert property ((quiet && $stable(delay_path_select)) [*2]
    |=> $stable(delay_readback))
    else $error("readback moved without a control");
  lane_rst_keep_a: assert property ((quiet && lrst && $stable(delay_path_select)) [*2]
    |=> $stable(delay_readback))
    else $error("lane reset disturbed a delay");
  for (genvar k = 0; k < 6; k++) begin : g_lane
    load_value_a: assert property (delay_load[k] && !nib_rst
      ##1 (quiet && $stable(delay_path_select)) [*2]
      |-> delay_readback[9*k +: 9] == $past(delay_load_value[9*k +: 9], 2))
      else $error("loaded tap not reported");
    step_move_a: assert property ((quiet && $stable(delay_path_select)) [*2]
      ##1 (dly_step[k] && !delay_load[k] && !nib_rst && $stable(delay_path_select))
      ##1 (quiet && $stable(delay_path_select)) [*2]
      |-> delay_readback[9*k +: 9] == $past(delay_readback[9*k +: 9], 3)
        + ($past(dly_inc[k], 2) ? 9'h001 : 9'h1FF))
      else $error("step did not move tap by one");
  end
  cover property (|delay_load);
  cover property (|(dly_step & dly_inc));
  cover property (nib_rst [*2]);
  cover property (|rx_rst);
endmodule

/* testbench/testbench.sv */
// Testbench joining the nibble end and the fabric end through one interface.
// Assumes a 50 MHz control clock and the software register map of the package.
`timescale 1ns/1ps
module testbench;
  logic        ref_clk = 1'b0;
  logic        srst    = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic        stop_in = 1'b0;
  logic        clk_in  = 1'b0;
  logic        arst_req = 1'b0;
  logic [5:0]  tx_data = 6'h12;
  logic [5:0]  tx_idle = 6'h2D;
  logic [5:0]  rx_pad  = 6'h3F;
  logic [15:0] rdata;
  logic [15:0] v;
  logic [5:0]  tx_pad, tri_ctl, rx_data, al_cal, rd_cal, td_cal, rx_trk, tx_trk;
  logic        start_out, stop_out, clk_dn, clk_up;
  int          error_cnt    = 0;
  int          total_checks = 0;
  always #10 ref_clk = ~ref_clk;
  nibble_if nibble_if_inst ();
  nibble_fabric nibble_fabric_inst (.REF_CLK(ref_clk), .SRST(srst), .ctl(nibble_if_inst.fabric),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .ASYNC_RST_REQ(arst_req));
  nibble_device nibble_device_inst (.REF_CLK(ref_clk), .SRST(srst),
    .ctl(nibble_if_inst.device), .TX_DATA(tx_data), .TX_IDLE(tx_idle), .TRI_IDLE(1'b1),
    .RX_PAD(rx_pad), .TX_PAD(tx_pad), .TRI_CTL(tri_ctl), .RX_DATA(rx_data),
    .RX_ALIGN_CAL(al_cal), .RX_DELAY_CAL(rd_cal), .TX_DELAY_CAL(td_cal), .RX_TRACK(rx_trk),
    .TX_TRACK(tx_trk), .CALIB_START_IN(stop_out), .CALIB_STOP_IN(stop_in),
    .CROSS_BYTE_CLK_IN(clk_in), .CALIB_START_OUT(start_out), .CALIB_STOP_OUT(stop_out),
    .CROSS_BYTE_CLK_DOWN(clk_dn), .CROSS_BYTE_CLK_UP(clk_up));
  nibble_chk nibble_chk_inst (.REF_CLK(ref_clk), .SRST(srst),
    .nib_rst(nibble_if_inst.nib_rst), .delay_path_select(nibble_if_inst.delay_path_select),
    .dly_step(nibble_if_inst.dly_step), .dly_inc(nibble_if_inst.dly_inc),
    .delay_load(nibble_if_inst.delay_load), .delay_load_value(nibble_if_inst.delay_load_value),
    .delay_readback(nibble_if_inst.delay_readback),
    .rx_calib_enable(nibble_if_inst.rx_calib_enable),
    .tx_calib_enable(nibble_if_inst.tx_calib_enable),
    .rx_rst(nibble_if_inst.rx_rst), .tx_rst(nibble_if_inst.tx_rst));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 v = rdata;
  endtask
  // The step sequence has a fixed length, so no busy polling is needed
  task automatic step(input logic [15:0] d);
    wr_reg(nibble_pkg::REG_STEP, d);
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic tap_is(input logic [15:0] l, input logic [15:0] e);
    wr_reg(nibble_pkg::REG_RBLANE, l);
    rd_reg(nibble_pkg::REG_RBVAL);
    chk("tap", e, v);
  endtask
  task automatic t_reset;
    rd_reg(4'hF);
    chk("unmapped", 16'h0000, v);
    wr_reg(nibble_pkg::REG_LOADVAL, 16'h0155);
    step(16'h0201);
    tap_is(16'h0000, 16'h0155);
    wr_reg(nibble_pkg::REG_CTRL, 16'h0001);
    repeat (4) @(posedge ref_clk);
    chk("pad", 16'(tx_idle), 16'(tx_pad));
    chk("tri", 16'h003F, 16'(tri_ctl));
    chk("rx", 16'h0000, 16'(rx_data));
    wr_reg(nibble_pkg::REG_CTRL, 16'h0000);
    tap_is(16'h0000, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_calib;
    wr_reg(nibble_pkg::REG_RXCAL, 16'h0025);
    wr_reg(nibble_pkg::REG_TXCAL, 16'h001A);
    wr_reg(nibble_pkg::REG_CTRL, 16'h0002);
    repeat (2) @(posedge ref_clk);
    chk("align", 16'h0025, 16'(al_cal));
    chk("rxdly", 16'h0025, 16'(rd_cal));
    chk("txdly", 16'h001A, 16'(td_cal));
    chk("rxtrk", 16'h0025, 16'(rx_trk));
    chk("txtrk", 16'h001A, 16'(tx_trk));
    wr_reg(nibble_pkg::REG_CTRL, 16'h0000);
    repeat (2) @(posedge ref_clk);
    chk("trkoff", 16'h0000, 16'({rx_trk, tx_trk}));
    $display("calibration test done");
  endtask
  // Lane 5 sits at the top of the readback bus; both paths kept apart
  task automatic t_delay;
    wr_reg(nibble_pkg::REG_SELECT, 16'h0000);
    wr_reg(nibble_pkg::REG_LOADVAL, 16'h01A5);
    step(16'h0220);
    step(16'h0120);
    tap_is(16'h0005, 16'h01A6);
    wr_reg(nibble_pkg::REG_SELECT, 16'h0020);
    tap_is(16'h0005, 16'h0000);
    wr_reg(nibble_pkg::REG_LOADVAL, 16'h00F0);
    step(16'h0220);
    step(16'h0020);
    tap_is(16'h0005, 16'h00EF);
    wr_reg(nibble_pkg::REG_SELECT, 16'h0000);
    tap_is(16'h0005, 16'h01A6);
    chk("calback", 16'h0025, 16'(rd_cal));
    $display("delay test done");
  endtask
  task automatic t_lane;
    wr_reg(nibble_pkg::REG_RXRST, 16'h0020);
    wr_reg(nibble_pkg::REG_TXRST, 16'h0020);
    repeat (3) @(posedge ref_clk);
    chk("pad", 16'({tx_idle[5], tx_data[4:0]}), 16'(tx_pad));
    chk("tri", 16'h0020, 16'(tri_ctl));
    chk("rx", 16'({1'b0, rx_pad[4:0]}), 16'(rx_data));
    tap_is(16'h0005, 16'h01A6);
    wr_reg(nibble_pkg::REG_SELECT, 16'h0020);
    tap_is(16'h0005, 16'h00EF);
    wr_reg(nibble_pkg::REG_RXRST, 16'h0000);
    wr_reg(nibble_pkg::REG_TXRST, 16'h0000);
    $display("lane reset test done");
  endtask
  task automatic t_tri;
    wr_reg(nibble_pkg::REG_TRISRC, 16'h003F);
    for (int i = 0; i < 2; i++) begin
      wr_reg(nibble_pkg::REG_TRIDIR, i ? 16'h0015 : 16'h002A);
      // Looked at just after the write edge: any flop after tridir_r on the route would still show the old bit
      #1;
      chk("tridir", i ? 16'h0015 : 16'h002A, 16'(tri_ctl));
    end
    wr_reg(nibble_pkg::REG_TRISRC, 16'h0000);
    $display("tristate test done");
  endtask
  // A step write while the previous one settles is refused, so the tap moves only once
  task automatic t_busy;
    wr_reg(nibble_pkg::REG_STEP, 16'h0120);
    rd_reg(nibble_pkg::REG_CHAIN);
    chk("busy", 16'h0001, v);
    repeat (6) @(posedge ref_clk);
    wr_reg(nibble_pkg::REG_STEP, 16'h0120);
    wr_reg(nibble_pkg::REG_STEP, 16'h0120);
    repeat (6) @(posedge ref_clk);
    tap_is(16'h0005, 16'h00F1);
    rd_reg(nibble_pkg::REG_CHAIN);
    chk("idle", 16'h0000, v);
    $display("busy test done");
  endtask
  // A one-cycle request is filtered out; a held one resets the nibble
  task automatic t_arst;
    @(posedge ref_clk);
    arst_req <= 1'b1;
    @(posedge ref_clk);
    arst_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    tap_is(16'h0005, 16'h00F1);
    @(posedge ref_clk);
    arst_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("apad", 16'(tx_idle), 16'(tx_pad));
    chk("arx", 16'h0000, 16'(rx_data));
    tap_is(16'h0005, 16'h0000);
    @(posedge ref_clk);
    arst_req <= 1'b0;
    repeat (6) @(posedge ref_clk);
    $display("async reset test done");
  endtask
  task automatic t_chain;
    @(posedge ref_clk);
    stop_in <= 1'b1;
    clk_in  <= 1'b1;
    @(posedge ref_clk);
    stop_in <= 1'b0;
    clk_in  <= 1'b0;
    #1 chk("relay", 16'h000F, 16'({start_out, stop_out, clk_dn, clk_up}));
    @(posedge ref_clk);
    #1 chk("loop", 16'h0004, 16'({start_out, stop_out, clk_dn, clk_up}));
    $display("chain test done");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    t_calib();
    t_delay();
    t_lane();
    t_tri();
    t_busy();
    t_arst();
    t_chain();
    stop_test();
  end
endmodule
